// ### ptd_decoder.v
// ptd_decoder.v: decoder for the parallel-transfer part of a 64-bit opcode,
// with a small apb register file for enable, status and an opcode counter.
// assumes: opcode and valid come from fetch logic on pclk (no sync needed);
// data-unit decode supplies the three-bit alu dst/src1 register fields.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "ptd_defines.vh"

module ptd_decoder
(
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // opcode from fetch
   input  wire [63:0] opcode_in,
   input  wire        opcode_valid_in,
   input  wire [2:0]  alu_dst_field_in,
   input  wire [2:0]  alu_src1_field_in,
   // decoded controls
   output reg         dec_valid_q,
   output reg  [3:0]  format_q,
   output reg         local_active_q,
   output reg         local_load_q,
   output reg  [1:0]  local_size_q,
   output reg         local_sext_q,
   output reg         local_scale_q,
   output reg  [3:0]  local_mode_q,
   output reg         local_rel_q,
   output reg  [2:0]  local_pointer_select_q,
   output reg  [15:0] local_imm_index_q,
   output reg  [6:0]  local_data_code_q,
   output reg         global_active_q,
   output reg         global_load_q,
   output reg  [1:0]  global_size_q,
   output reg         global_sext_q,
   output reg         global_scale_q,
   output reg  [2:0]  global_mode_q,
   output reg         global_rel_q,
   output reg  [2:0]  global_pointer_select_q,
   output reg  [14:0] global_imm_index_q,
   output reg  [6:0]  global_data_code_q,
   output reg         move_active_q,
   output reg         field_move_q,
   output reg  [6:0]  move_src_code_q,
   output reg  [6:0]  move_dst_code_q,
   output reg         duplicate_q,
   output reg  [2:0]  item_select_q,
   output reg  [6:0]  alu_dst_code_q,
   output reg  [6:0]  alu_src1_code_q,
   output reg         cond_en_q,
   output reg  [3:0]  cond_code_q,
   output reg         cond_result_write_q,
   output reg         cond_global_q,
   output reg         cond_src_choice_q,
   output reg         protect_n_q,
   output reg         protect_c_q,
   output reg         protect_v_q,
   output reg         protect_latched_v_q,
   output reg         protect_z_q
);

   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   reg         enable_q;      // decode enable, software written
   reg  [31:0] count_q;       // opcodes decoded since reset
   reg  [38:0] last_pt_q;     // last parallel field decoded
   wire        apb_acc;       // access phase
   wire        a_ctrl;        // address hits
   wire        a_stat;
   wire        a_cnt;
   wire        a_last;
   wire        a_hit;

   assign pready  = 1'b1;     // zero wait states, every access
   assign apb_acc = psel & penable;
   assign a_ctrl  = (paddr[3:0] == `PTD_A_CTRL);
   assign a_stat  = (paddr[3:0] == `PTD_A_STAT);
   assign a_cnt   = (paddr[3:0] == `PTD_A_COUNT);
   assign a_last  = (paddr[3:0] == `PTD_A_LAST);
   // upper address bits must be zero; anything else is unmapped
   assign a_hit   = (paddr[11:4] == 8'h00) & (a_ctrl | a_stat | a_cnt | a_last);
   assign pslverr = apb_acc & ~a_hit;

   // read mux; unmapped and reserved bits read as zero
   always @*
   begin
      prdata = 32'h0000_0000;
      if (a_hit & a_ctrl)
         prdata = {31'h0000_0000, enable_q};
      else if (a_hit & a_stat)
         prdata = {27'h000_0000, format_q, dec_valid_q};
      else if (a_hit & a_cnt)
         prdata = count_q;
      else if (a_hit & a_last)
         prdata = {25'h000_0000, last_pt_q[38:32]};
   end

   // control register write, taken at the access edge only
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         enable_q <= `PTD_CTRL_RST;
      else if (apb_acc & pwrite & a_hit & a_ctrl)
         enable_q <= pwdata[0];
   end

   // ----------------------------------------------------------------------
   // format recognition
   // ----------------------------------------------------------------------
   wire [38:0] pt;            // parallel-transfer portion
   reg  [3:0]  fmt_d;
   wire        is_cond;       // global-only or conditional family (lmode top bits zero)

   assign pt      = opcode_in[`PTD_PT_RANGE];
   // unused bits arrive as zero, so lmode top bits zero marks the
   // global-only and conditional families
   assign is_cond = (pt[`PTD_LMODE_HI] == `PTD_COND_HI);

   // one of ten formats from the parallel field
   always @*
   begin
      fmt_d = `PTD_F_NONE;
      if (!is_cond)
      begin
         if (pt[`PTD_GSEL])
            fmt_d = `PTD_F_DPAR;
         else if (pt[`PTD_LLONG])
            fmt_d = `PTD_F_LLONG;
         else if (pt[`PTD_MVKIND] == `PTD_MV_REG)
            fmt_d = `PTD_F_MOVE;
         else if (pt[`PTD_MVKIND] == `PTD_MV_FIELD)
            fmt_d = `PTD_F_FMOVE;
         else
            fmt_d = `PTD_F_NOND;
      end
      else
      begin
         if (pt[`PTD_GSEL])
            fmt_d = pt[`PTD_GRM_SEL] ? `PTD_F_CGLB : `PTD_F_GLONG;
         else if (pt[`PTD_MVKIND] == `PTD_MV_REG)
            fmt_d = `PTD_F_CMOVE;
         else if (pt[`PTD_MVKIND] == `PTD_MV_FIELD)
            fmt_d = `PTD_F_CFMOVE;
         else
            fmt_d = `PTD_F_CNOND;
      end
   end

   // ----------------------------------------------------------------------
   // field extraction (combinational next values)
   // ----------------------------------------------------------------------
   wire f_dp;                 // format flags
   wire f_ll;
   wire f_gl;
   wire f_cg;
   wire f_mv;
   wire f_fm;
   wire f_nd;
   wire cond_fmt;

   assign f_dp     = (fmt_d == `PTD_F_DPAR);
   assign f_ll     = (fmt_d == `PTD_F_LLONG);
   assign f_gl     = (fmt_d == `PTD_F_GLONG);
   assign f_cg     = (fmt_d == `PTD_F_CGLB);
   assign f_mv     = (fmt_d == `PTD_F_MOVE) | (fmt_d == `PTD_F_CMOVE);
   assign f_fm     = (fmt_d == `PTD_F_FMOVE) | (fmt_d == `PTD_F_CFMOVE);
   assign f_nd     = (fmt_d == `PTD_F_NOND) | (fmt_d == `PTD_F_CNOND);
   assign cond_fmt = is_cond & ~f_gl;

   wire        loc_d;         // local transfer present
   wire        glb_d;         // global transfer present
   wire [6:0]  loc_code_d;
   wire [6:0]  glb_code_d;
   wire [6:0]  mv_src_d;
   wire [6:0]  mv_dst_d;
   wire [3:0]  adst_bank_d;
   wire [3:0]  as1_bank_d;

   assign loc_d = ~is_cond;
   assign glb_d = f_dp | f_gl | f_cg;

   // local data register: d bank unless the long-offset form gives a bank
   assign loc_code_d = f_ll ? {pt[`PTD_BANK4], pt[`PTD_LDREG]}
                            : {`PTD_DBANK, pt[`PTD_LDREG]};

   // global register: short bank (msb zero) in double parallel, else bank
   assign glb_code_d = f_dp ? {1'b0, pt[`PTD_BANK3], pt[`PTD_GREG]}
                            : {pt[`PTD_BANK4], pt[`PTD_GREG]};

   // move source: field moves read a d register, moves use srcbank
   assign mv_src_d = f_fm ? {`PTD_DBANK, pt[`PTD_SRC]}
                          : {pt[`PTD_SRCBANK], pt[`PTD_SRC]};
   assign mv_dst_d = {pt[`PTD_BANK4], pt[`PTD_DST]};

   // alu banks only in non-d forms; others imply the d bank
   assign adst_bank_d = f_nd ? pt[`PTD_BANK4] : `PTD_DBANK;
   assign as1_bank_d  = f_nd ? pt[`PTD_SRCBANK] : `PTD_DBANK;

   // ----------------------------------------------------------------------
   // output registers: every field of one opcode lands on the same edge,
   // so downstream units never see a mix of two opcodes
   // ----------------------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dec_valid_q             <= 1'b0;
         format_q                <= `PTD_F_NONE;
         local_active_q          <= 1'b0;
         local_load_q            <= 1'b0;
         local_size_q            <= 2'h0;
         local_sext_q            <= 1'b0;
         local_scale_q           <= 1'b0;
         local_mode_q            <= 4'h0;
         local_rel_q             <= 1'b0;
         local_pointer_select_q  <= 3'h0;
         local_imm_index_q       <= 16'h0000;
         local_data_code_q       <= 7'h00;
         global_active_q         <= 1'b0;
         global_load_q           <= 1'b0;
         global_size_q           <= 2'h0;
         global_sext_q           <= 1'b0;
         global_scale_q          <= 1'b0;
         global_mode_q           <= 3'h0;
         global_rel_q            <= 1'b0;
         global_pointer_select_q <= 3'h0;
         global_imm_index_q      <= 15'h0000;
         global_data_code_q      <= 7'h00;
         move_active_q           <= 1'b0;
         field_move_q            <= 1'b0;
         move_src_code_q         <= 7'h00;
         move_dst_code_q         <= 7'h00;
         duplicate_q             <= 1'b0;
         item_select_q           <= 3'h0;
         alu_dst_code_q          <= 7'h00;
         alu_src1_code_q         <= 7'h00;
         cond_en_q               <= 1'b0;
         cond_code_q             <= 4'h0;
         cond_result_write_q     <= 1'b0;
         cond_global_q           <= 1'b0;
         cond_src_choice_q       <= 1'b0;
         protect_n_q             <= 1'b0;
         protect_c_q             <= 1'b0;
         protect_v_q             <= 1'b0;
         protect_latched_v_q     <= 1'b0;
         protect_z_q             <= 1'b0;
         count_q                 <= 32'h0000_0000;
         last_pt_q               <= 39'h00_0000_0000;
      end
      else
      begin
         // valid is a one-cycle pulse per decoded opcode
         dec_valid_q <= opcode_valid_in & enable_q;
         if (opcode_valid_in & enable_q)
         begin
            format_q  <= fmt_d;
            count_q   <= count_q + 32'h0000_0001;
            last_pt_q <= pt;
            // local address unit
            local_active_q         <= loc_d;
            local_load_q           <= loc_d & (f_dp ? pt[`PTD_L_DP]
                                                    : pt[`PTD_L_ST]);
            local_size_q           <= pt[`PTD_LSIZE];
            local_sext_q           <= loc_d & pt[`PTD_LSEXT];
            local_scale_q          <= loc_d & pt[`PTD_LSCALE];
            local_mode_q           <= pt[`PTD_LMODE];
            local_rel_q            <= loc_d & ~f_dp & ~f_ll & pt[`PTD_LRM];
            local_pointer_select_q <= pt[`PTD_LPTR];
            // long form carries a 16-bit offset, short forms three bits
            local_imm_index_q      <= f_ll ? pt[`PTD_LLONGOFF]
                                           : {13'h0000, pt[`PTD_LIMX]};
            local_data_code_q      <= loc_code_d;
            // global address unit
            global_active_q         <= glb_d;
            global_load_q           <= glb_d & pt[`PTD_L_ST];
            global_size_q           <= pt[`PTD_GSIZE];
            global_sext_q           <= glb_d & pt[`PTD_GSEXT];
            global_scale_q          <= glb_d & pt[`PTD_GSCALE];
            global_mode_q           <= pt[`PTD_GMODE];
            global_rel_q            <= (f_gl | f_cg) & pt[`PTD_GRM];
            global_pointer_select_q <= pt[`PTD_GPTR];
            global_imm_index_q      <= f_gl ? pt[`PTD_GLONG]
                                            : {12'h000, pt[`PTD_GIMX]};
            global_data_code_q      <= glb_code_d;
            // move path
            move_active_q   <= f_mv | f_fm;
            field_move_q    <= f_fm;
            move_src_code_q <= mv_src_d;
            move_dst_code_q <= mv_dst_d;
            duplicate_q     <= f_fm & pt[`PTD_DUP];
            item_select_q   <= f_fm ? pt[`PTD_ITEM] : 3'h0;
            // alu write-back codes
            alu_dst_code_q  <= {adst_bank_d, alu_dst_field_in};
            alu_src1_code_q <= {as1_bank_d, alu_src1_field_in};
            // condition and status protection only in conditional forms
            cond_en_q           <= cond_fmt;
            cond_code_q         <= cond_fmt ? pt[`PTD_COND] : 4'h0;
            cond_result_write_q <= cond_fmt & pt[`PTD_CRES];
            cond_global_q       <= f_cg & pt[`PTD_CGLB];
            cond_src_choice_q   <= cond_fmt & pt[`PTD_CSRC];
            protect_n_q         <= cond_fmt & pt[`PTD_PROT_N];
            protect_c_q         <= cond_fmt & pt[`PTD_PROT_C];
            protect_v_q         <= cond_fmt & pt[`PTD_PROT_V];
            // the overflow protect also shields the latched overflow bit
            protect_latched_v_q <= cond_fmt & pt[`PTD_PROT_V];
            protect_z_q         <= cond_fmt & pt[`PTD_PROT_Z];
         end
      end
   end

endmodule // ptd_decoder

// ### ptd_decoder_assertions.sv
// ptd_decoder_assertions.sv: port-level checks for the opcode decoder.
// assumes: bound into ptd_decoder; one pclk domain, presetn async active low.
`timescale 1ns/1ps

module ptd_decoder_chk
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [63:0] opcode_in,
   input wire        opcode_valid_in,
   input wire        dec_valid_q,
   input wire [3:0]  format_q,
   input wire        local_load_q,
   input wire [1:0]  local_size_q,
   input wire        local_sext_q,
   input wire [1:0]  global_size_q,
   input wire [6:0]  global_data_code_q,
   input wire [6:0]  move_src_code_q,
   input wire [6:0]  move_dst_code_q,
   input wire [2:0]  item_select_q,
   input wire        cond_en_q,
   input wire [3:0]  cond_code_q,
   input wire        protect_v_q,
   input wire        protect_latched_v_q
);
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic        en_q;  // shadow of the decode enable bit
   logic [38:0] op_q;  // transfer part seen at the previous edge
   wire         acc = opcode_valid_in && en_q;       // opcode taken at this edge
   wire         loc = opcode_in[38:37] != 2'h0;      // local format family
   wire         mv  = acc && loc && !opcode_in[16] && !opcode_in[24]; // move family

   // enable is shadowed from apb writes, since internals are out of sight
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_q <= 1'b1;
         op_q <= 39'h0;
      end
      else
      begin
         if (psel && penable && pwrite && paddr == 12'h000)
            en_q <= pwdata[0];
         op_q <= opcode_in[38:0];
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_one_cycle;
      dec_valid_q == $past(acc);
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("strobe not one cycle after accept");
   property p_hold;
      !acc |=> $stable(format_q) && $stable(move_src_code_q);
   endproperty
   a_hold: assert property (p_hold) else $error("fields moved without accept");
   property p_local;
      acc && loc |=> local_size_q == op_q[30:29] && local_sext_q == op_q[31] && !cond_en_q;
   endproperty
   a_local: assert property (p_local) else $error("local size or sign wrong");
   property p_global;
      acc && opcode_in[16] |=> global_size_q == op_q[8:7];
   endproperty
   a_global: assert property (p_global) else $error("global size wrong");
   property p_dpar;
      acc && loc && opcode_in[16] |=> local_load_q == op_q[21] && format_q == 4'h1
         && global_data_code_q == {1'b0, op_q[20:18], op_q[12:10]};
   endproperty
   a_dpar: assert property (p_dpar) else $error("double parallel decode wrong");
   property p_move;
      mv && opcode_in[14:13] == 2'h0 |=> move_src_code_q == {op_q[9:6], op_q[12:10]}
         && move_dst_code_q == {op_q[21:18], op_q[5:3]};
   endproperty
   a_move: assert property (p_move) else $error("move codes wrong");
   property p_fmove;
      mv && opcode_in[14:13] == 2'h1 |=> move_src_code_q == {4'h4, op_q[12:10]}
         && item_select_q == op_q[24:22];
   endproperty
   a_fmove: assert property (p_fmove) else $error("field move wrong");
   property p_protect;
      acc && !loc && !opcode_in[16] |=> protect_v_q == op_q[26]
         && protect_latched_v_q == op_q[26] && cond_code_q == op_q[35:32];
   endproperty
   a_protect: assert property (p_protect) else $error("protect or cond wrong");
endmodule // ptd_decoder_chk

bind ptd_decoder ptd_decoder_chk u_chk
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .opcode_in, .opcode_valid_in,
   .dec_valid_q, .format_q, .local_load_q, .local_size_q, .local_sext_q, .global_size_q,
   .global_data_code_q, .move_src_code_q, .move_dst_code_q, .item_select_q, .cond_en_q,
   .cond_code_q, .protect_v_q, .protect_latched_v_q
);

// ### ptd_defines.vh
// ptd_defines.vh: constants for the parallel-transfer opcode decoder.
// assumes: included by its bare name from ptd_decoder.v; definitions only.
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

// ----------------------------------------------------------------------
// opcode field positions (parallel-transfer portion, bits 38..0)
// ----------------------------------------------------------------------
`define PTD_PT_RANGE      38:0
`define PTD_LMODE_HI      38:37
`define PTD_LMODE         38:35
`define PTD_COND          35:32
`define PTD_LDREG         34:32
`define PTD_LSEXT         31
`define PTD_CSRC          31
`define PTD_LSIZE         30:29
`define PTD_CRES          30
`define PTD_CGLB          29
`define PTD_LSCALE        28
`define PTD_PROT_N        28
`define PTD_LPTR          27:25
`define PTD_PROT_C        27
`define PTD_PROT_V        26
`define PTD_PROT_Z        25
`define PTD_LLONG         24
`define PTD_GIMX          24:22
`define PTD_ITEM          24:22
`define PTD_LRM           23
`define PTD_GLONG         36:22
`define PTD_L_DP          21
`define PTD_BANK4         21:18
`define PTD_BANK3         20:18
`define PTD_L_ST          17
`define PTD_GSEL          16
`define PTD_GMODE         15:13
`define PTD_MVKIND        14:13
`define PTD_LLONGOFF      15:0
`define PTD_GREG          12:10
`define PTD_SRC           12:10
`define PTD_GSEXT         9
`define PTD_SRCBANK       9:6
`define PTD_GSIZE         8:7
`define PTD_GSCALE        6
`define PTD_DUP           6
`define PTD_GPTR          5:3
`define PTD_DST           5:3
`define PTD_LIMX          2:0
`define PTD_GRM_SEL       1
`define PTD_GRM           0

// ----------------------------------------------------------------------
// constant codes
// ----------------------------------------------------------------------
`define PTD_DBANK         4'h4
`define PTD_MV_REG        2'h0
`define PTD_MV_FIELD      2'h1
`define PTD_COND_HI       2'h0

// format numbers 1..10
`define PTD_F_NONE        4'h0
`define PTD_F_DPAR        4'h1
`define PTD_F_MOVE        4'h2
`define PTD_F_FMOVE       4'h3
`define PTD_F_LLONG       4'h4
`define PTD_F_GLONG       4'h5
`define PTD_F_NOND        4'h6
`define PTD_F_CMOVE       4'h7
`define PTD_F_CFMOVE      4'h8
`define PTD_F_CGLB        4'h9
`define PTD_F_CNOND       4'hA

// ----------------------------------------------------------------------
// apb register map (byte addresses) and reset values
// ----------------------------------------------------------------------
`define PTD_A_CTRL        4'h0
`define PTD_A_STAT        4'h4
`define PTD_A_COUNT       4'h8
`define PTD_A_LAST        4'hC
`define PTD_CTRL_RST      1'h1

`endif

// ### ptd_fetch_model.sv
// ptd_fetch_model.sv: behavioural fetch stage handing opcodes to the decoder.
// assumes: send is called just after a rising pclk edge.
`timescale 1ns/1ps

module ptd_fetch_model
(
   input  wire         pclk,
   output logic [63:0] opcode_in,
   output logic        opcode_valid_in,
   output logic [2:0]  alu_dst_field_in,
   output logic [2:0]  alu_src1_field_in
);
   // quiet bus at time zero
   initial
   begin
      opcode_in         = 64'h0;
      opcode_valid_in   = 1'b0;
      alu_dst_field_in  = 3'h0;
      alu_src1_field_in = 3'h0;
   end

   // one opcode per edge; idle word flips so a decoder ignoring valid shows it
   task automatic send(input logic [38:0] pt, input logic [5:0] fld, input logic last);
      opcode_in         <= {25'h0, pt}; // unused bits come as zero
      opcode_valid_in   <= 1'b1;
      alu_dst_field_in  <= fld[5:3];
      alu_src1_field_in <= fld[2:0];
      @(posedge pclk);
      if (last)
      begin
         opcode_valid_in <= 1'b0;
         opcode_in       <= ~{25'h0, pt};
      end
   endtask
endmodule // ptd_fetch_model

// ### test_parallel_transfer_opcode_decoder.sv
// test_parallel_transfer_opcode_decoder.sv: directed bench for the opcode decoder.
// assumes: ptd_fetch_model feeds opcodes; the apb master lives here.
`timescale 1ns/1ps
`define CHK(w, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s expected %0h seen %0h", w, e, g); end end

module test_parallel_transfer_opcode_decoder;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;   // rd: read data taken at the access edge
   logic        err;                  // slave error taken at the access edge
   int          n_errors = 0, num_checks = 0;
   wire         pready, pslverr, opcode_valid_in;
   wire  [31:0] prdata;
   wire  [63:0] opcode_in;
   wire  [2:0]  alu_dst_field_in, alu_src1_field_in, local_pointer_select_q;
   wire  [2:0]  global_pointer_select_q, item_select_q;
   wire         dec_valid_q, local_load_q, local_sext_q, local_scale_q, global_load_q;
   wire         global_sext_q, field_move_q, duplicate_q, cond_en_q, cond_result_write_q;
   wire         cond_global_q, cond_src_choice_q, protect_n_q, protect_c_q, protect_v_q;
   wire         protect_latched_v_q, protect_z_q, global_scale_q, move_active_q;
   wire  [3:0]  format_q, cond_code_q;
   wire  [1:0]  local_size_q, global_size_q;
   wire  [15:0] local_imm_index_q;
   wire  [14:0] global_imm_index_q;
   wire  [6:0]  local_data_code_q, global_data_code_q, move_src_code_q, move_dst_code_q;
   wire  [6:0]  alu_dst_code_q, alu_src1_code_q;
   // one opcode of each tested format, fields left to right from bit 38
   localparam logic [38:0] F1 = {4'hA,3'h5,1'h1,2'h2,1'h1,3'h3,3'h6,1'h1,3'h5,1'h0,1'h1,
                                 3'h2,3'h7,1'h0,2'h1,1'h0,3'h1,3'h4};
   localparam logic [38:0] F2 = {4'h8,3'h2,1'h0,2'h0,1'h0,3'h1,3'h2,4'h7,1'h1,4'h0,
                                 3'h3,4'hC,3'h6,3'h0};
   localparam logic [38:0] F3 = {4'hC,3'h4,1'h1,2'h1,1'h0,3'h2,3'h2,4'h1,3'h0,2'h1,
                                 3'h5,1'h1,2'h0,1'h1,3'h3,3'h7};
   localparam logic [38:0] F6 = {4'hA,3'h1,4'h0,3'h4,3'h0,4'h9,1'h1,2'h0,2'h2,3'h0,
                                 4'hD,3'h0,3'h1};
   localparam logic [38:0] F9 = {3'h0,4'hB,7'h5A,3'h3,4'h6,2'h3,3'h5,3'h2,1'h1,2'h2,
                                 1'h1,3'h4,3'h3};
   localparam logic [38:0] F7 = {3'h0,4'h3,7'h25,3'h0,4'h2,5'h0,3'h1,4'h5,3'h2,3'h0};

   ptd_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .opcode_in, .opcode_valid_in, .alu_dst_field_in, .alu_src1_field_in,
      .dec_valid_q, .format_q, .local_active_q(), .local_load_q, .local_size_q, .local_sext_q,
      .local_scale_q, .local_mode_q(), .local_rel_q(), .local_pointer_select_q,
      .local_imm_index_q, .local_data_code_q, .global_active_q(), .global_load_q,
      .global_size_q, .global_sext_q, .global_scale_q, .global_mode_q(), .global_rel_q(),
      .global_pointer_select_q, .global_imm_index_q, .global_data_code_q, .move_active_q,
      .field_move_q, .move_src_code_q, .move_dst_code_q, .duplicate_q, .item_select_q,
      .alu_dst_code_q, .alu_src1_code_q, .cond_en_q, .cond_code_q, .cond_result_write_q,
      .cond_global_q, .cond_src_choice_q, .protect_n_q, .protect_c_q, .protect_v_q,
      .protect_latched_v_q, .protect_z_q);
   ptd_fetch_model u_fetch (.pclk, .opcode_in, .opcode_valid_in, .alu_dst_field_in,
      .alu_src1_field_in);

   // 50 MHz clock
   always #10 pclk = ~pclk;

   // apb transfer; one idle edge after it so psel is never re-driven
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (int t = 0; t < 20 && pready !== 1'b1; t++)
         @(posedge pclk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // the sequence needs well under 200 cycles; 20 us means a hang
   initial
   begin
      #20000;
      n_errors++;
      close_out();
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `CHK("reset fields", 5'h00, {dec_valid_q, format_q})
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h1, rd)
      apb(1'b1, 12'h004, 32'hF);  // read-only place, write must not land
      apb(1'b0, 12'h004, 32'h0);
      `CHK("stat", 33'h0, {err, rd})
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      `CHK("unmapped wr", 1'b1, err)
      apb(1'b0, 12'h803, 32'h0);
      `CHK("unmapped rd", 33'h1_0000_0000, {err, rd})
      // double parallel, d-bank alu codes
      u_fetch.send(F1, 6'h13, 1'b1);
      #1;
      `CHK("fmt1", 4'h1, format_q)
      `CHK("local", 5'h1B, {local_load_q, local_size_q, local_sext_q, local_scale_q})
      `CHK("global", 4'h2, {global_load_q, global_size_q, global_sext_q})
      `CHK("short bank", 7'h2F, global_data_code_q)
      `CHK("local d", 7'h25, local_data_code_q)
      `CHK("ptrs", 6'h19, {local_pointer_select_q, global_pointer_select_q})
      `CHK("imm", 31'h0002_0006, {local_imm_index_q, global_imm_index_q})
      `CHK("alu d", 14'h1123, {alu_dst_code_q, alu_src1_code_q})
      `CHK("no cond", 6'h00, {cond_en_q, protect_n_q, protect_c_q, protect_v_q, protect_z_q, protect_latched_v_q})
      @(posedge pclk);
      // move then field move back to back
      u_fetch.send(F2, 6'h00, 1'b0);
      u_fetch.send(F3, 6'h00, 1'b1);
      #1;
      `CHK("back to back", 5'h13, {dec_valid_q, format_q})
      `CHK("fmove codes", 14'h128B, {move_src_code_q, move_dst_code_q})
      `CHK("fmove flags", 6'h3A, {move_active_q, field_move_q, duplicate_q, item_select_q})
      @(posedge pclk);
      // non-d data unit banks
      u_fetch.send(F6, 6'h2E, 1'b1);
      #1;
      `CHK("fmt6", 5'h06, {cond_en_q, format_q})
      `CHK("alu banks", 14'h26EE, {alu_dst_code_q, alu_src1_code_q})
      @(posedge pclk);
      // conditional global
      u_fetch.send(F9, 6'h00, 1'b1);
      #1;
      `CHK("fmt9", 8'h9B, {format_q, cond_code_q})
      `CHK("cond9", 4'hD, {cond_en_q, cond_src_choice_q, cond_result_write_q, cond_global_q})
      `CHK("prot9", 5'h16, {protect_n_q, protect_c_q, protect_v_q, protect_latched_v_q, protect_z_q})
      `CHK("glob9", 12'hDB2, {global_load_q, global_size_q, global_sext_q, global_scale_q, global_data_code_q})
      `CHK("gim9", 15'h3, global_imm_index_q)
      @(posedge pclk);
      // disabled decode must drop the opcode
      apb(1'b1, 12'h000, 32'h0);
      u_fetch.send(F7, 6'h00, 1'b1);
      #1;
      `CHK("refused", 5'h09, {dec_valid_q, format_q})
      @(posedge pclk);
      apb(1'b1, 12'h000, 32'h1);
      u_fetch.send(F7, 6'h00, 1'b1);
      #1;
      `CHK("fmt7", 8'h73, {format_q, cond_code_q})
      `CHK("cond7", 4'hA, {cond_en_q, cond_src_choice_q, cond_result_write_q, cond_global_q})
      `CHK("prot7", 5'h09, {protect_n_q, protect_c_q, protect_v_q, protect_latched_v_q, protect_z_q})
      `CHK("move7", 7'h29, move_src_code_q)
      @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("count", 32'h6, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("last", 32'h3, rd)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("status", 32'hE, rd)
      close_out();
   end
endmodule // test_parallel_transfer_opcode_decoder
